/* fer_device.sv */
`timescale 1ns/10ps
// ****************************************************************
// Floating-point error reporting, core end
// ****************************************************************
module fer_device (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Mode control
  input  wire logic       native_report_select_i,
  // Exception source
  input  wire logic       exc_valid_i,
  input  wire logic [2:0] exc_class_i,
  input  wire logic [6:0] exc_flags_i,
  input  wire logic       exc_clear_i,
  // Instruction boundary
  input  wire logic       boundary_valid_i,
  input  wire logic       boundary_fp_i,
  input  wire logic       boundary_nowait_i,
  output logic            boundary_ready_o,
  // External interrupt taken
  input  wire logic       ext_int_i,
  // Native interrupt
  output logic            native_int_o,
  output logic [7:0]      native_vector_o,
  // Status
  output logic            frozen_o,
  output logic            pending_o,
  // Link
  fer_link_if.device      link
);
  // ****************************************************************
  // Local state
  // ****************************************************************
  typedef struct packed {
    fer_pkg::fer_state_e state;
    logic                immediate;
    logic                err_pin;
    logic                nat_int;
    logic [7:0]          vector;
  } fer_dev_s;

  fer_dev_s st_reg;
  fer_dev_s st_next;
  logic     ignore_active;
  logic     ignore_n_sync;
  logic     immed_now;
  logic     compat;
  logic     wait_boundary;

  // ****************************************************************
  // Classification helpers
  // ****************************************************************
  // Immediate or deferred classification
  function automatic logic is_immediate(input logic [2:0] cls,
                                        input logic [6:0] f);
    logic trans_fault;
    logic store_fault;
    trans_fault = (cls == fer_pkg::FER_CLS_TRANSC) &&
                  (f[fer_pkg::EXC_STACK] || f[fer_pkg::EXC_INVALID] ||
                   f[fer_pkg::EXC_DENORMAL]);
    store_fault = (cls == fer_pkg::FER_CLS_STORE) &&
                  (|(f & ~(7'h01 << fer_pkg::EXC_PRECISION)));
    return trans_fault || store_fault;
  endfunction

  // Waiting instruction at a boundary; no-wait ones excluded
  function automatic logic is_wait_boundary(input logic valid,
                                            input logic fp,
                                            input logic nowait);
    return valid && fp && !nowait;
  endfunction

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  fer_sync u_sync (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .d_i         (link.ignore_fault_in),
    .q_o         (ignore_n_sync)
  );

  assign compat        =
    (native_report_select_i == fer_pkg::MODE_COMPAT);
  assign ignore_active = compat && !ignore_n_sync;
  assign immed_now     = is_immediate(exc_class_i, exc_flags_i);
  assign wait_boundary = is_wait_boundary(boundary_valid_i, boundary_fp_i,
                                          boundary_nowait_i);

  // ****************************************************************
  // Reporting state machine
  // ****************************************************************
  always_comb begin
    st_next         = st_reg;
    st_next.nat_int = 1'b0;
    case (st_reg.state)
      fer_pkg::FER_IDLE: begin
        st_next.err_pin = 1'b0;
        if (exc_valid_i) begin
          // Anything not immediate is deferred
          st_next.immediate = immed_now;
          st_next.state     = fer_pkg::FER_PEND;
          if (immed_now && compat && !ignore_active) begin
            st_next.err_pin = 1'b1;
          end
        end
      end
      fer_pkg::FER_PEND: begin
        if (exc_clear_i) begin
          st_next.state   = fer_pkg::FER_IDLE;
          st_next.err_pin = 1'b0;
        end else if (ignore_active) begin
          st_next.err_pin = 1'b0;
        end else begin
          if (st_reg.immediate && compat) begin
            st_next.err_pin = 1'b1;
          end
          if (wait_boundary) begin
            // Freeze at wait or FP instruction
            st_next.state = fer_pkg::FER_FROZEN;
            if (compat) begin
              st_next.err_pin = 1'b1;
            end else begin
              st_next.nat_int = 1'b1;
              st_next.vector  = fer_pkg::NATIVE_VECTOR;
            end
          end
        end
      end
      fer_pkg::FER_FROZEN: begin
        if (exc_clear_i) begin
          st_next.state   = fer_pkg::FER_IDLE;
          st_next.err_pin = 1'b0;
        end else if (ext_int_i || !compat) begin
          // Handler runs; error stays pending
          st_next.state = fer_pkg::FER_REPORT;
        end
      end
      fer_pkg::FER_REPORT: begin
        if (exc_clear_i) begin
          st_next.state   = fer_pkg::FER_IDLE;
          st_next.err_pin = 1'b0;
        end else if (!ignore_active && wait_boundary) begin
          st_next.state = fer_pkg::FER_FROZEN;
          if (!compat) begin
            st_next.nat_int = 1'b1;
          end
        end
      end
      default: begin
        st_next.state = fer_pkg::FER_IDLE;
      end
    endcase
    if (!compat) begin
      st_next.err_pin = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{state: fer_pkg::FER_IDLE, immediate: 1'b0,
                  err_pin: 1'b0, nat_int: 1'b0, vector: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Stall wait/FP instructions while an error is pending, not ignored and not being cleared, and all but no-wait instructions while frozen; no-wait always pass
  always_comb begin
    boundary_ready_o = 1'b1;
    if (st_reg.state == fer_pkg::FER_FROZEN) begin
      boundary_ready_o = 1'b0;
    end else if (boundary_fp_i && !boundary_nowait_i && !ignore_active &&
                 (st_reg.state != fer_pkg::FER_IDLE) && !exc_clear_i) begin
      boundary_ready_o = 1'b0;
    end
    if (boundary_nowait_i) begin
      boundary_ready_o = 1'b1;
    end
  end

  assign link.fpu_error_out = !st_reg.err_pin;
  assign native_int_o       = st_reg.nat_int;
  assign native_vector_o    = st_reg.vector;
  assign frozen_o           = (st_reg.state == fer_pkg::FER_FROZEN);
  assign pending_o          = (st_reg.state != fer_pkg::FER_IDLE);
endmodule

/* fer_pkg.sv */
// ****************************************************************
// Shared constants and types
// ****************************************************************
package fer_pkg;

  // Interrupt vectors and request line
  localparam logic [7:0] NATIVE_VECTOR    = 8'h10;
  localparam logic [7:0] COMPAT_VECTOR    = 8'h75;
  localparam logic [7:0] FORWARD_VECTOR   = 8'h02;
  localparam int         COPROC_IRQ_LINE  = 13;

  // Reporting mode values
  localparam logic       MODE_NATIVE      = 1'b1;
  localparam logic       MODE_COMPAT      = 1'b0;
  localparam logic       NATIVE_SEL_RESET = 1'b0;

  // Instruction classes
  typedef enum logic [2:0] {
    FER_CLS_ARITH   = 3'h0,
    FER_CLS_TRANSC  = 3'h1,
    FER_CLS_STORE   = 3'h2,
    FER_CLS_OTHER   = 3'h3
  } fer_class_e;

  // Exception flag bit positions
  localparam int EXC_INVALID   = 0;
  localparam int EXC_DENORMAL  = 1;
  localparam int EXC_ZERODIV   = 2;
  localparam int EXC_OVERFLOW  = 3;
  localparam int EXC_UNDERFLOW = 4;
  localparam int EXC_PRECISION = 5;
  localparam int EXC_STACK     = 6;
  localparam int EXC_W         = 7;

  // Device states
  typedef enum logic [3:0] {
    FER_IDLE    = 4'h1,
    FER_PEND    = 4'h2,
    FER_FROZEN  = 4'h4,
    FER_REPORT  = 4'h8
  } fer_state_e;

  // Glue latch states
  typedef enum logic [1:0] {
    FER_G_IDLE  = 2'h1,
    FER_G_REQ   = 2'h2
  } fer_glue_e;

endpackage

/* fer_link_if.sv */
`timescale 1ns/10ps
// ****************************************************************
// Error pin link between core and glue logic
// ****************************************************************
interface fer_link_if;
  logic fpu_error_out;
  logic ignore_fault_in;

  modport device (
    output fpu_error_out,
    input  ignore_fault_in
  );

  modport host (
    input  fpu_error_out,
    output ignore_fault_in
  );
endinterface

/* fer_sync.sv */
`timescale 1ns/10ps
// ****************************************************************
// Two-stage synchroniser
// ****************************************************************
module fer_sync (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } fer_sync_s;

  fer_sync_s st_reg;
  fer_sync_s st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  // Reset to inactive pin level (one)
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule

/* fer_host.sv */
`timescale 1ns/10ps
// ****************************************************************
// Glue latch and interrupt request, system end
// ****************************************************************
module fer_host (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Handler side
  input  wire logic port_access_i,
  output logic      coproc_irq_o,
  output logic [7:0] irq_vector_o,
  output logic      ignore_active_o,
  // Link
  fer_link_if.host  link
);
  typedef struct packed {
    fer_pkg::fer_glue_e state;
    logic               irq;
    logic               ignore;
    logic               err_prev;
  } fer_host_s;

  fer_host_s st_reg;
  fer_host_s st_next;
  logic      err_sync_n;
  logic      err_active;

  fer_sync u_sync (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .d_i         (link.fpu_error_out),
    .q_o         (err_sync_n)
  );

  assign err_active = !err_sync_n;

  always_comb begin
    st_next          = st_reg;
    st_next.err_prev = err_active;
    case (st_reg.state)
      fer_pkg::FER_G_IDLE: begin
        if (err_active && !st_reg.err_prev) begin
          // Request on error edge
          st_next.irq   = 1'b1;
          st_next.state = fer_pkg::FER_G_REQ;
        end
      end
      fer_pkg::FER_G_REQ: begin
        if (port_access_i) begin
          st_next.irq    = 1'b0;
          st_next.ignore = err_active;
          st_next.state  = fer_pkg::FER_G_IDLE;
        end
      end
      default: begin
        st_next.state = fer_pkg::FER_G_IDLE;
      end
    endcase
    // Ignore never outlives the error
    if (!err_active) begin
      st_next.ignore = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{state: fer_pkg::FER_G_IDLE, irq: 1'b0,
                  ignore: 1'b0, err_prev: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.ignore_fault_in = !st_reg.ignore;
  assign coproc_irq_o         = st_reg.irq;
  assign irq_vector_o         = fer_pkg::COMPAT_VECTOR;
  assign ignore_active_o      = st_reg.ignore;
endmodule

/* fer_chk.sv */
`timescale 1ns/10ps
// ****************************************************************
// Link and report checker
// ****************************************************************
module fer_chk (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Link
  input  wire logic       fpu_error_out,
  input  wire logic       ignore_fault_in,
  // Device and host
  input  wire logic       native_report_select_i,
  input  wire logic       exc_clear_i,
  input  wire logic       boundary_valid_i,
  input  wire logic       boundary_nowait_i,
  input  wire logic       boundary_ready_o,
  input  wire logic       frozen_o,
  input  wire logic       ext_int_i,
  input  wire logic       native_int_o,
  input  wire logic [7:0] native_vector_o,
  input  wire logic       coproc_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_native_pin_idle: assert property (
    native_report_select_i |-> fpu_error_out)
    else $error("pin active in native mode");
  a_native_vector: assert property (
    native_int_o |-> native_vector_o == fer_pkg::NATIVE_VECTOR)
    else $error("wrong native vector");
  a_freeze_sets_pin: assert property (
    $rose(frozen_o) && !native_report_select_i |-> !fpu_error_out)
    else $error("freeze without error pin");
  a_nowait_no_stall: assert property (
    boundary_valid_i && boundary_nowait_i |-> boundary_ready_o)
    else $error("no-wait instruction stalled");
  a_clear_drops_pin: assert property (
    exc_clear_i |=> fpu_error_out)
    else $error("pin held after clear");
  a_pin_raises_irq: assert property (
    $fell(fpu_error_out) |-> ##[1:5] coproc_irq_o)
    else $error("no request after error pin");
  a_ignore_off_pin: assert property (
    $rose(fpu_error_out) |-> ##[1:6] ignore_fault_in)
    else $error("ignore left on after clear");
  a_frozen_holds: assert property (
    frozen_o && !ext_int_i && !exc_clear_i && !native_report_select_i
    |=> frozen_o)
    else $error("left freeze without interrupt");
  a_ignore_no_freeze: assert property (
    !ignore_fault_in && !$past(ignore_fault_in, 3) |-> !$rose(frozen_o))
    else $error("froze while ignore active");

  c_freeze: cover property ($rose(frozen_o) && !native_report_select_i);
  c_native: cover property (native_int_o);
  c_ignore: cover property (!ignore_fault_in && boundary_ready_o);
endmodule

/* tb.sv */
`timescale 1ns/10ps
// ****************************************************************
// Bench
// ****************************************************************
module tb;
  logic       clock_i                = 1'b0;
  logic       rst_n_i                = 1'b0;
  logic       native_report_select_i = 1'b0;
  logic       exc_valid_i            = 1'b0;
  logic [2:0] exc_class_i            = 3'h0;
  logic [6:0] exc_flags_i            = 7'h00;
  logic       exc_clear_i            = 1'b0;
  logic       boundary_valid_i       = 1'b0;
  logic       boundary_fp_i          = 1'b1;
  logic       boundary_nowait_i      = 1'b0;
  logic       ext_int_i              = 1'b0;
  logic       port_access_i          = 1'b0;
  logic       boundary_ready_o;
  logic       native_int_o;
  logic [7:0] native_vector_o;
  logic       frozen_o;
  logic       pending_o;
  logic       coproc_irq_o;
  logic [7:0] irq_vector_o;
  logic       ignore_active_o;
  int         num_errors             = 0;
  int         total_checks           = 0;

  fer_link_if link ();
  fer_device i_fer_device (.*, .link(link));
  fer_host   i_fer_host   (.*, .link(link));
  fer_chk    i_fer_chk    (.*, .fpu_error_out(link.fpu_error_out),
                           .ignore_fault_in(link.ignore_fault_in));

  always #2 clock_i = ~clock_i;

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return frozen_o;
      1: return coproc_irq_o;
      2: return link.ignore_fault_in;
      default: return native_int_o;
    endcase
  endfunction

  // Bounded wait for a flag
  task automatic wt(input int s, input logic v);
    int n;
    #1;
    for (n = 0; n < 20 && pick(s) !== v; n++) begin
      @(posedge clock_i);
      #1;
    end
    if (pick(s) !== v) begin
      $display("Error %0t: wait %0d timed out", $time, s);
      num_errors++;
      finish_test();
    end
  endtask

  task automatic exc(input logic [2:0] c, input logic [6:0] f);
    @(posedge clock_i) exc_valid_i <= 1'b1;
    exc_class_i <= c;
    exc_flags_i <= f;
    @(posedge clock_i) exc_valid_i <= 1'b0;
  endtask

  // Freeze, interrupt, handler entry with ignore
  task automatic freeze();
    @(posedge clock_i) boundary_valid_i <= 1'b1;
    wt(0, 1'b1);
    chk(link.fpu_error_out, 1'b0);
    chk(boundary_ready_o, 1'b0);
    @(posedge clock_i) boundary_valid_i <= 1'b0;
    wt(1, 1'b1);
    chk(irq_vector_o === fer_pkg::COMPAT_VECTOR, 1'b1);
    chk(frozen_o, 1'b1);
    @(posedge clock_i) ext_int_i <= 1'b1;
    @(posedge clock_i) ext_int_i <= 1'b0;
    port_access_i <= 1'b1;
    @(posedge clock_i) port_access_i <= 1'b0;
    wt(2, 1'b0);
    chk(coproc_irq_o, 1'b0);
    chk(ignore_active_o, 1'b1);
    chk(frozen_o, 1'b0);
    repeat (3) @(posedge clock_i);
    boundary_valid_i <= 1'b1;
    #1 chk(boundary_ready_o, 1'b1);
    @(posedge clock_i) boundary_valid_i <= 1'b0;
    #1 chk(frozen_o, 1'b0);
  endtask

  task automatic clr();
    @(posedge clock_i) exc_clear_i <= 1'b1;
    @(posedge clock_i) exc_clear_i <= 1'b0;
    @(posedge clock_i);
    #1 chk(link.fpu_error_out, 1'b1);
    wt(2, 1'b1);
    chk(pending_o, 1'b0);
    repeat (3) @(posedge clock_i);
  endtask

  // Class and flag table, deferred or immediate
  task automatic t_table();
    logic [2:0] cl [6] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h1};
    logic [6:0] fl [6] = '{7'h01, 7'h40, 7'h04, 7'h20, 7'h10, 7'h20};
    logic [5:0] im     = 6'b000110;
    int         i;
    for (i = 0; i < 6; i++) begin
      exc(cl[i], fl[i]);
      @(posedge clock_i) boundary_nowait_i <= 1'b1;
      boundary_valid_i <= 1'b1;
      #1 chk(boundary_ready_o, 1'b1);
      chk(link.fpu_error_out, !im[i]);
      chk(pending_o, 1'b1);
      @(posedge clock_i) boundary_nowait_i <= 1'b0;
      boundary_valid_i <= 1'b0;
      #1 chk(frozen_o, 1'b0);
      freeze();
      clr();
    end
    $display("table test done");
  endtask

  // Ignore while pending drops the pin, release restores it
  task automatic t_ignore();
    exc(3'h2, 7'h01);
    wt(1, 1'b1);
    @(posedge clock_i) port_access_i <= 1'b1;
    @(posedge clock_i) port_access_i <= 1'b0;
    wt(2, 1'b0);
    repeat (4) @(posedge clock_i);
    #1 chk(link.fpu_error_out, 1'b1);
    chk(boundary_ready_o, 1'b1);
    chk(pending_o, 1'b1);
    wt(2, 1'b1);
    repeat (3) @(posedge clock_i);
    #1 chk(link.fpu_error_out, 1'b0);
    wt(1, 1'b1);
    freeze();
    clr();
    $display("ignore test done");
  endtask

  task automatic t_native();
    @(posedge clock_i) native_report_select_i <= 1'b1;
    exc(3'h0, 7'h08);
    @(posedge clock_i) boundary_valid_i <= 1'b1;
    wt(3, 1'b1);
    chk(native_vector_o === fer_pkg::NATIVE_VECTOR, 1'b1);
    chk(link.fpu_error_out, 1'b1);
    chk(coproc_irq_o, 1'b0);
    @(posedge clock_i) boundary_valid_i <= 1'b0;
    clr();
    $display("native test done");
  endtask

  initial begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_table();
    t_ignore();
    t_native();
    finish_test();
  end
endmodule
